// [rtl/lsmc_pkg.sv]
// constants, register map and carrier types of the light sensor measure control block
package lsmc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_MOD_DISABLE = 8'h40;
	localparam logic [7:0] IDX_ENABLE = 8'h80;
	localparam logic [7:0] IDX_MODE_A = 8'h81;
	localparam logic [7:0] IDX_MODE_B = 8'h82;
	localparam logic [7:0] IDX_ITER_LIMIT = 8'hc0;
	localparam logic [7:0] IDX_STATUS = 8'hc1;
	localparam logic [7:0] IDX_LIGHT_DATA = 8'hc2;
	localparam logic [7:0] IDX_RAW_RESULT = 8'hc3;

	// reset values
	localparam logic [7:0] RST_MOD_DISABLE = 8'h00;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_MODE_A = 8'h04;
	localparam logic [7:0] RST_MODE_B = 8'h0c;
	localparam logic [7:0] RST_ITER_LIMIT = 8'h00;

	// field positions
	localparam int BIT_FIRST_MOD_OFF = 0;
	localparam int BIT_SECOND_MOD_OFF = 1;
	localparam int BIT_POWER_ON = 0;
	localparam int BIT_LIGHT_ON = 1;
	localparam int BIT_FLICKER_ON = 6;
	localparam int BIT_STOP_ITER = 7;
	localparam int BIT_DOUBLE_STEP = 6;
	localparam int BIT_ONE_SHOT = 5;
	localparam int BIT_LSTAT_Q = 4;
	localparam int BIT_END_Q = 7;
	localparam int BIT_SUM_Q = 6;
	localparam int BIT_GAIN_Q = 5;
	localparam int BIT_STAT_STOPPED = 4;
	localparam int BIT_STAT_SLEEP = 5;

	// writable bit masks, reserved bits read zero
	localparam logic [7:0] MASK_MOD_DISABLE = 8'h03;
	localparam logic [7:0] MASK_ENABLE = 8'h43;

	// field widths
	localparam int SCALE_W = 4;
	localparam int TOP_POS_W = 5;
	localparam int GAIN_W = 4;
	localparam int RESULT_W = 32;
	localparam int DATA_W = 16;
	localparam int CHAN_N = 2;

	typedef enum logic [2:0] {
		LSMC_REC_LIGHT_STATUS,
		LSMC_REC_LIGHT_DATA,
		LSMC_REC_GAIN,
		LSMC_REC_CHECKSUM,
		LSMC_REC_END_MARKER
	} lsmc_rec_kind_t;

	// one record offered to the measurement queue
	typedef struct packed {
		lsmc_rec_kind_t kind;
		logic [DATA_W-1:0] data;
	} lsmc_record_t;

	// engine events, all one-cycle pulses on the block clock
	typedef struct packed {
		logic iteration_done;
		logic sequence_done;
		logic light_done;
		logic flicker_done;
		logic analog_saturation;
	} lsmc_events_t;
endpackage

// [rtl/lsmc_top.sv]
// light sensor measure control: apb registers, run control, gain step, scaling, queue records
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps

// Overview of operation
// - second modulator off bit set keeps modulator channel 1 inactive.
// - first modulator off bit set keeps modulator channel 0 inactive.
// - flicker enable bit 6 starts flicker detection on one, stops on zero.
// - light enable bit 1 turns light measurement on or off.
// - power-on bit 0 starts oscillator so timers and modulators run.
// - writing power-on zero stops oscillator, clears light enable, keeps flicker enable as written.
// - stop mode ends measuring after nth iteration, clears both enables, keeps power.
// - double step mode drops gain two steps on analogue saturation when gain above one, to zero from one.
// - one-shot mode runs one sequencer cycle then asserts sleep after interrupt.
// - light status record goes into queue with light data when enabled.
// - four-bit scale, reset four, top zero bits needed for scaled light data.
// - internal light result up to 26 bits, held in 32-bit register.
// - five-bit top position, reset twelve, picks top bit of the result.
// - end marker bit appends end marker after each flicker measurement.
// - checksum bit appends flicker checksum after each flicker measurement.
// - gain bit appends used gain after each flicker measurement.
module lsmc_top (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// measurement engine side
	input wire lsmc_pkg::lsmc_events_t events,
	input wire logic [lsmc_pkg::RESULT_W-1:0] raw_result,
	input wire logic [lsmc_pkg::GAIN_W-1:0] gain_now,
	input wire logic agc_active,
	input wire logic [lsmc_pkg::DATA_W-1:0] flicker_checksum,
	// run control outputs
	output logic oscillator_on,
	output logic [lsmc_pkg::CHAN_N-1:0] modulator_active,
	output logic flicker_run,
	output logic light_run,
	output logic cleared_enable_bit_clr,
	output logic sleep_after_irq,
	// gain command
	output logic gain_set,
	output logic [lsmc_pkg::GAIN_W-1:0] gain_next,
	// queue records
	output lsmc_pkg::lsmc_record_t rec,
	output logic rec_valid,
	input wire logic rec_ready
);

	typedef enum {
		Q_IDLE,
		Q_LSTAT,
		Q_LDATA,
		Q_GAIN,
		Q_SUM,
		Q_END
	} lsmc_qstate_t;

	function automatic logic lsmc_hit(input logic [11:0] addr, input logic [7:0] idx);
		lsmc_hit = (addr == {2'b00, idx, 2'b00});
	endfunction

	logic rst_meta_n;
	logic rst_sync_n;
	logic [7:0] mod_disable;
	logic [7:0] enable_reg;
	logic [7:0] mode_a;
	logic [7:0] mode_b;
	logic [7:0] iter_limit;
	logic [7:0] iter_count;
	logic stopped;
	logic [31:0] result_hold;
	logic [15:0] light_data;
	logic light_scaled;
	logic pend_light;
	logic pend_flicker;
	logic [lsmc_pkg::GAIN_W-1:0] gain_hold;
	lsmc_qstate_t qstate;
	lsmc_qstate_t next_qstate;

	// reset release through two flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// apb decode; one wait state, write lands on the pready edge
	wire access = psel & penable;
	wire apb_done = access & pready;
	wire wr = apb_done & pwrite;
	wire hit_mod = lsmc_hit(paddr, lsmc_pkg::IDX_MOD_DISABLE);
	wire hit_en = lsmc_hit(paddr, lsmc_pkg::IDX_ENABLE);
	wire hit_ma = lsmc_hit(paddr, lsmc_pkg::IDX_MODE_A);
	wire hit_mb = lsmc_hit(paddr, lsmc_pkg::IDX_MODE_B);
	wire hit_it = lsmc_hit(paddr, lsmc_pkg::IDX_ITER_LIMIT);
	wire hit_st = lsmc_hit(paddr, lsmc_pkg::IDX_STATUS);
	wire hit_ld = lsmc_hit(paddr, lsmc_pkg::IDX_LIGHT_DATA);
	wire hit_rr = lsmc_hit(paddr, lsmc_pkg::IDX_RAW_RESULT);
	wire mapped = hit_mod | hit_en | hit_ma | hit_mb | hit_it | hit_st | hit_ld | hit_rr;
	wire wr_en = wr & hit_en;
	wire wr_st = wr & hit_st;

	wire power_bit = enable_reg[lsmc_pkg::BIT_POWER_ON];
	wire flick_bit = enable_reg[lsmc_pkg::BIT_FLICKER_ON];
	wire light_bit = enable_reg[lsmc_pkg::BIT_LIGHT_ON];
	wire measuring = power_bit & (flick_bit | light_bit);

	// iteration end: counter reaches the limit, so limit zero is one run
	wire iter_last = events.iteration_done & measuring & (iter_count == iter_limit);
	wire auto_stop = mode_a[lsmc_pkg::BIT_STOP_ITER] & iter_last;

	wire power_off_wr = wr_en & ~pwdata[lsmc_pkg::BIT_POWER_ON];

	logic [7:0] next_enable;
	always_comb begin
		next_enable = enable_reg;
		if (auto_stop) begin
			next_enable[lsmc_pkg::BIT_FLICKER_ON] = 1'b0;
			next_enable[lsmc_pkg::BIT_LIGHT_ON] = 1'b0;
		end
		if (wr_en) begin
			next_enable = pwdata[7:0] & lsmc_pkg::MASK_ENABLE;
			if (power_off_wr) begin
				next_enable[lsmc_pkg::BIT_LIGHT_ON] = 1'b0;
			end
		end
	end

	// register file; reserved bits masked so they never store
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mod_disable <= lsmc_pkg::RST_MOD_DISABLE;
			enable_reg <= lsmc_pkg::RST_ENABLE;
			mode_a <= lsmc_pkg::RST_MODE_A;
			mode_b <= lsmc_pkg::RST_MODE_B;
			iter_limit <= lsmc_pkg::RST_ITER_LIMIT;
		end else begin
			if (wr & hit_mod)
				mod_disable <= pwdata[7:0] & lsmc_pkg::MASK_MOD_DISABLE;
			enable_reg <= next_enable;
			if (wr & hit_ma)
				mode_a <= pwdata[7:0];
			if (wr & hit_mb)
				mode_b <= pwdata[7:0];
			if (wr & hit_it)
				iter_limit <= pwdata[7:0];
		end
	end

	// iteration counter restarts whenever software rewrites the enables
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			iter_count <= 8'h00;
		end else if (wr_en || iter_last) begin
			iter_count <= 8'h00;
		end else if (events.iteration_done && measuring) begin
			iter_count <= iter_count + 8'h01;
		end
	end

	// sticky stop flag: write one clears, a stop in the same cycle wins
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			stopped <= 1'b0;
		end else begin
			stopped <= auto_stop | (stopped & ~(wr_st & pwdata[lsmc_pkg::BIT_STAT_STOPPED]));
		end
	end

	// run control outputs
	wire one_shot = mode_a[lsmc_pkg::BIT_ONE_SHOT];
	wire seq_end = one_shot & power_bit & events.sequence_done;
	wire sleep_clr = (wr_st & pwdata[lsmc_pkg::BIT_STAT_SLEEP]) | power_off_wr;
	logic [lsmc_pkg::CHAN_N-1:0] next_mod_active;

	genvar ch;
	generate
		for (ch = 0; ch < lsmc_pkg::CHAN_N; ch++) begin : g_mod
			assign next_mod_active[ch] = next_enable[lsmc_pkg::BIT_POWER_ON] & ~mod_disable[ch];
		end
	endgenerate

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			oscillator_on <= 1'b0;
			modulator_active <= '0;
			flicker_run <= 1'b0;
			light_run <= 1'b0;
			cleared_enable_bit_clr <= 1'b0;
			sleep_after_irq <= 1'b0;
		end else begin
			oscillator_on <= next_enable[lsmc_pkg::BIT_POWER_ON];
			modulator_active <= next_mod_active;
			flicker_run <= next_enable[lsmc_pkg::BIT_POWER_ON] & next_enable[lsmc_pkg::BIT_FLICKER_ON];
			light_run <= next_enable[lsmc_pkg::BIT_POWER_ON] & next_enable[lsmc_pkg::BIT_LIGHT_ON];
			cleared_enable_bit_clr <= power_off_wr;
			// one-shot sleep, set wins over clear
			sleep_after_irq <= seq_end | (sleep_after_irq & ~sleep_clr);
		end
	end

	// gain step on analogue saturation
	wire double_step = mode_a[lsmc_pkg::BIT_DOUBLE_STEP];
	wire sat_step = events.analog_saturation & agc_active & (gain_now != '0);
	wire [lsmc_pkg::GAIN_W-1:0] gain_one = gain_now - 4'h1;
	wire [lsmc_pkg::GAIN_W-1:0] gain_two = (gain_now > 4'h1) ? gain_now - 4'h2 : 4'h0;

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			gain_set <= 1'b0;
			gain_next <= '0;
			gain_hold <= '0;
		end else begin
			gain_set <= sat_step;
			if (sat_step)
				gain_next <= double_step ? gain_two : gain_one;
			if (events.flicker_done)
				gain_hold <= gain_now;
		end
	end

	// result scaling
	wire [lsmc_pkg::SCALE_W-1:0] scale = mode_a[lsmc_pkg::SCALE_W-1:0];
	wire [lsmc_pkg::TOP_POS_W-1:0] top_pos = mode_b[lsmc_pkg::TOP_POS_W-1:0];
	// top position: move the chosen top bit up to bit 31
	wire [31:0] aligned = result_hold << (5'd31 - top_pos);
	wire [31:0] scale_zero_mask = ~(32'hffffffff >> scale);
	wire can_scale = (scale != 4'h0) && ((aligned & scale_zero_mask) == 32'h00000000);
	wire [31:0] shifted = aligned << scale;
	wire [15:0] next_light_data = can_scale ? shifted[31:16] : aligned[31:16];

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			result_hold <= 32'h00000000;
			light_data <= 16'h0000;
			light_scaled <= 1'b0;
		end else begin
			if (events.light_done)
				result_hold <= raw_result;
			light_data <= next_light_data;
			light_scaled <= can_scale;
		end
	end

	// queue records; events during a busy record are held pending
	wire q_take = rec_valid & rec_ready;
	wire q_free = (qstate == Q_IDLE) | (q_take & (next_qstate == Q_IDLE));
	wire start_light = pend_light & (qstate == Q_IDLE);
	wire start_flick = pend_flicker & ~pend_light & (qstate == Q_IDLE);
	wire want_gain = mode_b[lsmc_pkg::BIT_GAIN_Q];
	wire want_sum = mode_b[lsmc_pkg::BIT_SUM_Q];
	wire want_end = mode_b[lsmc_pkg::BIT_END_Q];

	always_comb begin
		next_qstate = qstate;
		case (qstate)
			Q_IDLE: begin
				if (pend_light)
					next_qstate = mode_a[lsmc_pkg::BIT_LSTAT_Q] ? Q_LSTAT : Q_LDATA;
				else if (pend_flicker && want_gain)
					next_qstate = Q_GAIN;
				else if (pend_flicker && want_sum)
					next_qstate = Q_SUM;
				else if (pend_flicker && want_end)
					next_qstate = Q_END;
			end
			Q_LSTAT: begin
				if (q_take)
					next_qstate = Q_LDATA;
			end
			Q_LDATA: begin
				if (q_take)
					next_qstate = Q_IDLE;
			end
			Q_GAIN: begin
				if (q_take)
					next_qstate = want_sum ? Q_SUM : (want_end ? Q_END : Q_IDLE);
			end
			Q_SUM: begin
				if (q_take)
					next_qstate = want_end ? Q_END : Q_IDLE;
			end
			Q_END: begin
				if (q_take)
					next_qstate = Q_IDLE;
			end
			default: next_qstate = Q_IDLE;
		endcase
	end

	// load only on entering a state, so a stalled record never changes
	wire rec_load = (next_qstate != qstate);
	lsmc_pkg::lsmc_record_t next_rec;
	always_comb begin
		next_rec = rec;
		case (rec_load ? next_qstate : Q_IDLE)
			// light status; live copies, the registered ones lag a cycle
			Q_LSTAT: next_rec = '{lsmc_pkg::LSMC_REC_LIGHT_STATUS,
				{11'h000, can_scale, scale}};
			Q_LDATA: next_rec = '{lsmc_pkg::LSMC_REC_LIGHT_DATA, next_light_data};
			Q_GAIN: next_rec = '{lsmc_pkg::LSMC_REC_GAIN, {12'h000, gain_hold}};
			Q_SUM: next_rec = '{lsmc_pkg::LSMC_REC_CHECKSUM, flicker_checksum};
			Q_END: next_rec = '{lsmc_pkg::LSMC_REC_END_MARKER, 16'hffff};
			default: next_rec = rec;
		endcase
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			qstate <= Q_IDLE;
			rec <= '{lsmc_pkg::LSMC_REC_LIGHT_STATUS, 16'h0000};
			rec_valid <= 1'b0;
			pend_light <= 1'b0;
			pend_flicker <= 1'b0;
		end else begin
			qstate <= next_qstate;
			rec <= next_rec;
			rec_valid <= (next_qstate != Q_IDLE);
			// new event wins over the start that consumes the old one
			pend_light <= events.light_done | (pend_light & ~start_light);
			pend_flicker <= (events.flicker_done & (want_gain | want_sum | want_end))
				| (pend_flicker & ~start_flick);
		end
	end

	// read mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		if (hit_mod)
			rd_mux = {24'h000000, mod_disable};
		if (hit_en)
			rd_mux = {24'h000000, enable_reg};
		if (hit_ma)
			rd_mux = {24'h000000, mode_a};
		if (hit_mb)
			rd_mux = {24'h000000, mode_b};
		if (hit_it)
			rd_mux = {24'h000000, iter_limit};
		if (hit_st)
			rd_mux = {16'h0000, iter_count, 2'b00, sleep_after_irq, stopped,
				light_scaled, q_free, measuring, oscillator_on};
		if (hit_ld)
			rd_mux = {16'h0000, light_data};
		if (hit_rr)
			rd_mux = result_hold;
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= access & ~pready;
			pslverr <= access & ~pready & ~mapped;
			if (access && !pready)
				prdata <= pwrite ? 32'h00000000 : rd_mux;
		end
	end

endmodule // lsmc_top

// [testbench/lsmc_top_chk.sv]
// concurrent checks on the ports of the light sensor measure control block
`timescale 1ns/100ps
module lsmc_top_chk (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// engine side
	input wire lsmc_pkg::lsmc_events_t events,
	input wire logic [3:0] gain_now,
	input wire logic agc_active,
	// run, gain and record outputs, record ready input
	input wire logic oscillator_on,
	input wire logic [1:0] modulator_active,
	input wire logic flicker_run,
	input wire logic light_run,
	input wire logic gain_set,
	input wire logic [3:0] gain_next,
	input wire lsmc_pkg::lsmc_record_t rec,
	input wire logic rec_valid,
	input wire logic rec_ready
);
	logic wr, dbl_q, lst_q;
	assign wr = psel && penable && pready && pwrite && !pslverr;
	// mode bits mirrored so gain and record checks know the mode
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dbl_q <= 1'b0;
			lst_q <= 1'b0;
		end else if (wr && paddr == 12'h204) begin
			dbl_q <= pwdata[6];
			lst_q <= pwdata[4];
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_access;
		psel && !penable ##1 psel && penable;
	endsequence
	// a lone light event with the queue idle before it
	sequence s_light_alone;
		events == 5'h04 && !rec_valid && !$past(rec_valid) && $past(events) == 5'h00;
	endsequence
	a_ready_after_access: assert property (s_access |=> pready)
		else $error("pready missing after access cycle");
	a_power_follows: assert property (
		wr && paddr == 12'h200 |-> ##2 oscillator_on == $past(pwdata[0], 2))
		else $error("oscillator does not follow power bit");
	a_run_needs_power: assert property (
		light_run || flicker_run || modulator_active != 2'h0 |-> oscillator_on)
		else $error("activity without power");
	a_mod_follow: assert property (
		wr && paddr == 12'h100 |-> ##2
		modulator_active == ({2{oscillator_on}} & ~$past(pwdata[1:0], 2)))
		else $error("modulator enables wrong");
	a_gain_step: assert property (
		events.analog_saturation && agc_active && gain_now != 4'h0 |=> gain_set &&
		gain_next == $past(gain_now) - ((dbl_q && $past(gain_now) > 4'h1) ? 4'h2 : 4'h1))
		else $error("gain step wrong");
	a_gain_zero_hold: assert property (
		events.analog_saturation && gain_now == 4'h0 |=> !gain_set)
		else $error("gain stepped below zero");
	a_record_start: assert property (
		s_light_alone |-> ##2 rec_valid && rec.kind == (lst_q ?
		lsmc_pkg::LSMC_REC_LIGHT_STATUS : lsmc_pkg::LSMC_REC_LIGHT_DATA))
		else $error("light record late or wrong kind");
	a_record_held: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec))
		else $error("record changed before taken");
	a_end_marker_value: assert property (
		rec_valid && rec.kind == lsmc_pkg::LSMC_REC_END_MARKER |-> rec.data == 16'hffff)
		else $error("end marker value wrong");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
endmodule // lsmc_top_chk

bind lsmc_top lsmc_top_chk lsmc_top_chk_inst (.clock(clock), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .events(events), .gain_now(gain_now), .agc_active(agc_active),
	.oscillator_on(oscillator_on), .modulator_active(modulator_active),
	.flicker_run(flicker_run), .light_run(light_run), .gain_set(gain_set),
	.gain_next(gain_next), .rec(rec), .rec_valid(rec_valid), .rec_ready(rec_ready));

// [testbench/tb.sv]
// self-checking bench for the light sensor measure control block
`timescale 1ns/100ps
module tb;
	localparam logic [11:0] mod_reg = 12'h100;
	localparam logic [11:0] en_reg = 12'h200;
	localparam logic [11:0] mode_a_reg = 12'h204;
	localparam logic [11:0] mode_b_reg = 12'h208;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, agc_active, err;
	logic oscillator_on, flicker_run, light_run, sleep_after_irq, gain_set, rec_valid, rec_ready;
	logic cleared_enable_bit_clr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, raw_result, rd, seed;
	logic [3:0] gain_now, gain_next;
	logic [15:0] flicker_checksum;
	logic [1:0] modulator_active;
	lsmc_pkg::lsmc_events_t events;
	lsmc_pkg::lsmc_record_t rec;
	logic [18:0] expq[$];
	int n_mismatch, cmp_count;
	lsmc_top lsmc_top_inst (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .events(events), .raw_result(raw_result), .gain_now(gain_now),
		.agc_active(agc_active), .flicker_checksum(flicker_checksum),
		.oscillator_on(oscillator_on), .modulator_active(modulator_active),
		.flicker_run(flicker_run), .light_run(light_run),
		.cleared_enable_bit_clr(cleared_enable_bit_clr),
		.sleep_after_irq(sleep_after_irq), .gain_set(gain_set), .gain_next(gain_next),
		.rec(rec), .rec_valid(rec_valid), .rec_ready(rec_ready));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// look between edges; the edge after pready shows high completes the transfer
		i = 0;
		#1;
		while (pready !== 1'b1 && i < 20) begin
			@(posedge clock);
			#1;
			i++;
		end
		if (pready !== 1'b1) begin
			n_mismatch++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		@(posedge clock);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		chk(rd, e, "read");
		chk({31'h0, err}, {31'h0, ee}, "slverr");
	endtask
	task automatic settle();
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic pulse(input logic [4:0] e);
		@(posedge clock);
		events <= lsmc_pkg::lsmc_events_t'(e);
		@(posedge clock);
		events <= 5'h00;
	endtask
	// compare the head record, then accept it after a random stall
	task automatic take();
		logic [18:0] e;
		int i;
		e = expq.pop_front();
		i = 0;
		do begin
			@(posedge clock);
			#1;
			i++;
		end while (rec_valid !== 1'b1 && i < 30);
		if (rec_valid !== 1'b1) begin
			n_mismatch++;
			end_of_test();
		end
		chk({13'h0, rec}, {13'h0, e}, "record");
		repeat (xs() % 3) @(posedge clock);
		@(posedge clock);
		rec_ready <= 1'b1;
		@(posedge clock);
		rec_ready <= 1'b0;
	endtask
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		repeat (100000) @(posedge clock);
		n_mismatch++;
		end_of_test();
	end
	initial begin
		logic [31:0] r, x, g, c;
		int k, m;
		logic f;
		seed = 32'd32;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		events = 5'h00;
		raw_result = 32'h0;
		gain_now = 4'h0;
		agc_active = 1'b1;
		flicker_checksum = 16'h0;
		rec_ready = 1'b0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		rdchk(mod_reg, 32'h0, 1'b0);
		rdchk(en_reg, 32'h0, 1'b0);
		rdchk(mode_a_reg, 32'h4, 1'b0);
		rdchk(mode_b_reg, 32'hc, 1'b0);
		rdchk(12'h404, 32'h0, 1'b1);
		x = xs();
		wr(mode_a_reg, x);
		rdchk(mode_a_reg, {24'h0, x[7:0]}, 1'b0);
		wr(mod_reg, 32'hffff_ffff);
		rdchk(mod_reg, 32'h3, 1'b0);
		wr(en_reg, 32'hffff_ffbf);
		rdchk(en_reg, 32'h3, 1'b0);
		for (k = 0; k < 4; k++) begin
			wr(mod_reg, k);
			settle();
			chk(modulator_active, ~k & 3, "modulators");
		end
		for (k = 0; k < 4; k++) begin
			wr(en_reg, {25'h0, k[1], 4'h0, k[0], 1'b1});
			settle();
			chk({flicker_run, light_run, oscillator_on}, {k[1], k[0], 1'b1}, "run");
		end
		wr(en_reg, 32'h42);
		#1;
		chk(cleared_enable_bit_clr, 1'b1, "enable clear pulse");
		settle();
		chk({flicker_run, light_run, oscillator_on, modulator_active, cleared_enable_bit_clr},
			6'h0, "off");
		rdchk(en_reg, 32'h40, 1'b0);
		for (k = 0; k < 2; k++) begin
			wr(mode_a_reg, 32'h4 | (k * 32'ha0));
			wr(en_reg, 32'h43);
			pulse(5'h08);
			pulse(5'h10);
			settle();
			chk({oscillator_on, light_run, flicker_run, sleep_after_irq},
				{1'b1, k == 0, k == 0, k == 1}, "stop");
			rdchk(en_reg, k ? 32'h1 : 32'h43, 1'b0);
			wr(en_reg, 32'h0);
		end
		g = 32'h0;
		for (m = 0; m < 2; m++) begin
			wr(mode_a_reg, m ? 32'h44 : 32'h04);
			for (k = 15; k >= 0; k--) begin
				@(posedge clock);
				gain_now <= k[3:0];
				pulse(5'h01);
				settle();
				if (k > 0) g = (m == 1 && k > 1) ? k - 2 : k - 1;
				chk(gain_next, g, "gain");
			end
		end
		wr(mode_a_reg, 32'h14);
		for (k = 0; k < 6; k++) begin
			r = xs() & (k < 3 ? 32'h1ff : 32'h1fff);
			x = r << 19;
			f = x[31:28] == 4'h0;
			if (f) x = x << 4;
			expq.push_back({lsmc_pkg::LSMC_REC_LIGHT_STATUS, 11'h0, f, 4'h4});
			expq.push_back({lsmc_pkg::LSMC_REC_LIGHT_DATA, x[31:16]});
			@(posedge clock);
			raw_result <= r;
			pulse(5'h04);
			take();
			take();
		end
		for (m = 0; m < 8; m++) begin
			wr(mode_b_reg, {24'h0, m[2:0], 5'h0c});
			g = xs();
			c = xs();
			@(posedge clock);
			gain_now <= g[3:0];
			flicker_checksum <= c[15:0];
			pulse(5'h02);
			if (m[0]) expq.push_back({lsmc_pkg::LSMC_REC_GAIN, 12'h0, g[3:0]});
			if (m[1]) expq.push_back({lsmc_pkg::LSMC_REC_CHECKSUM, c[15:0]});
			if (m[2]) expq.push_back({lsmc_pkg::LSMC_REC_END_MARKER, 16'hffff});
			while (expq.size() > 0) take();
			settle();
			chk(rec_valid, 0, "queue idle");
		end
		end_of_test();
	end
endmodule // tb
